// ---- dv/hmcr_host_model.sv ----
/*
 holds a configuration host that issues single-cycle accesses.
 assumes the block answers one cycle after the request edge.
*/
`timescale 1ns/1ps
module hmcr_host_model
   import hmcr_pkg::*;
(
   input wire logic clk,
   output hmcr_cfg_req_t cfg_req,
   input wire logic [31:0] cfg_rdata,
   input wire logic target_abort,
   input wire logic abort_data_junk
);
   // ***************************************************************
   // access task
   // ***************************************************************
   initial cfg_req = '0;

   task automatic access(input logic w, input logic [7:0] a, input logic [3:0] be,
      input logic [31:0] wd, output logic [31:0] rd, output logic [1:0] ab);
      @(posedge clk);
      #1 cfg_req = '{w, ~w, a, be, wd};
      @(posedge clk);
      // strobes drop to zero; address, enable and data lines show inverted values, not the last ones
      #1 cfg_req = {2'b00, ~cfg_req[43:0]};
      rd = cfg_rdata;
      ab = {target_abort, abort_data_junk};
   endtask
endmodule

// ---- dv/hmcr_regs_sva.sv ----
/*
 holds port-level assertions for hmcr_regs.
 assumes hmcr_pkg is compiled first; bound to every hmcr_regs instance.
*/
`timescale 1ns/1ps
module hmcr_regs_sva
   import hmcr_pkg::*;
(
   input wire logic clk,
   input wire logic resetn,
   input hmcr_cfg_req_t cfg_req,
   input wire logic [31:0] cfg_rdata,
   input wire logic cfg_rvalid,
   input wire logic abort_condition,
   input wire logic target_abort,
   input wire logic abort_data_junk,
   input hmcr_rom_load_t rom_load,
   input wire logic phy_program_load,
   input wire logic phy_program_permit,
   input wire logic phy_enhancement_gate,
   input wire logic tx_underrun,
   input hmcr_link_ctl_t link_ctl,
   input hmcr_pm_caps_t pm_caps,
   input wire logic general_pin_a_en,
   input wire logic general_pin_b_en,
   input wire logic serial_clk_in,
   input wire logic serial_data_in
);
   // ***************************************************************
   // assertions
   // ***************************************************************
   default clocking @(posedge clk);
   endclocking
   default disable iff (!resetn);

   misc_rsvd_a: assert property (
      cfg_rvalid && !abort_data_junk && $past(cfg_req.addr) == HMCR_MISC_OFS |->
      (cfg_rdata & ~HMCR_MISC_WMASK) == 32'h0) else $error("misc reserved bit set");
   link_rsvd_a: assert property (
      cfg_rvalid && !abort_data_junk && $past(cfg_req.addr) == HMCR_LINK_OFS |->
      (cfg_rdata & ~HMCR_LINK_WMASK) == 32'h0) else $error("link reserved bit set");
   caps_copy_a: assert property (
      cfg_rvalid && !abort_data_junk && $past(cfg_req.addr) == HMCR_MISC_OFS |->
      pm_caps == {cfg_rdata[15], cfg_rdata[13], cfg_rdata[10]}) else $error("caps differ");
   pin_release_a: assert property (
      serial_clk_in || serial_data_in |-> !general_pin_a_en && !general_pin_b_en)
      else $error("pin driven while routed");
   abort_cause_a: assert property (
      target_abort |-> !abort_data_junk && $past(abort_condition && (cfg_req.rd || cfg_req.wr)))
      else $error("abort without cause");
   gate_low_a: assert property (
      !phy_enhancement_gate [*2] |-> link_ctl == {3'b000, HMCR_THR_1K7})
      else $error("enhancement active with gate low");
   retry_thr_a: assert property (
      tx_underrun && phy_enhancement_gate |=> link_ctl.tx_thresh == HMCR_THR_2K)
      else $error("no store and forward after underrun");
   rom_bit_a: assert property (
      rom_load.load |=> phy_program_load && phy_program_permit == $past(rom_load.data[6]))
      else $error("rom bit 6 not passed on");
endmodule

bind hmcr_regs hmcr_regs_sva u_sva (.*);

// ---- dv/hmcr_regs_test.sv ----
/*
 holds the self-checking bench for hmcr_regs.
 assumes the host model and checker files are compiled before it.
*/
`timescale 1ns/1ps
module hmcr_regs_test
   import hmcr_pkg::*;
;
   // ***************************************************************
   // signals
   // ***************************************************************
   logic clk = 0, link_clk_in = 0, resetn = 0, abort_condition = 0;
   logic phy_enhancement_gate = 0, tx_underrun = 0, tx_packet_done = 0;
   logic general_pin_a_in = 0, general_pin_b_in = 0, general_pin_a_out = 0;
   logic general_pin_b_out = 0, general_pin_a_oe = 0, general_pin_b_oe = 0;
   logic clkrun_n_in = 1, bus_busy = 0, link_busy = 0;
   logic cfg_rvalid, target_abort, abort_data_junk, phy_program_load, phy_program_permit;
   logic general_pin_a_en, general_pin_b_en, serial_clk_in, serial_data_in;
   logic bus_clk_int, link_clk_int;
   logic general_pin_a_o, general_pin_b_o, clkrun_n_o, clkrun_n_en;
   logic [31:0] cfg_rdata, rdat, m, l, wd;
   logic [3:0] be;
   logic [1:0] ab;
   hmcr_cfg_req_t cfg_req;
   hmcr_rom_load_t rom_load = '0;
   hmcr_link_ctl_t link_ctl;
   hmcr_pm_caps_t pm_caps;
   logic [7:0] at [3] = '{HMCR_MISC_OFS, HMCR_LINK_OFS, 8'hf8};
   logic [31:0] cw [6] = '{32'hffffffff, 32'h0, 32'hffffffff, 32'h0, 32'h2000, 32'h1000};
   int seed = 27, error_cnt = 0, samples_checked = 0, k;

   always #4 clk = ~clk;
   always #5 link_clk_in = ~link_clk_in;

   hmcr_regs DUT (.*);
   hmcr_host_model host (.clk(clk), .cfg_req(cfg_req), .cfg_rdata(cfg_rdata),
      .target_abort(target_abort), .abort_data_junk(abort_data_junk));

   // ***************************************************************
   // tasks and expectations
   // ***************************************************************
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic stop_test();
      $display("checks %0d errors %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   task automatic rd(input logic [7:0] a);
      host.access(1'b0, a, 4'hf, 32'h0, rdat, ab);
      chk(cfg_rvalid, 1'b1);
   endtask

   task automatic wr(input logic [7:0] a, input logic [3:0] b, input logic [31:0] d);
      host.access(1'b1, a, b, d, rdat, ab);
   endtask

   function automatic logic [31:0] upd(input logic [31:0] o, input logic [31:0] w,
      input logic [3:0] b, input logic [31:0] msk);
      logic [31:0] bm;
      bm = {{8{b[3]}}, {8{b[2]}}, {8{b[1]}}, {8{b[0]}}} & msk;
      return (o & ~bm) | (w & bm);
   endfunction

   function automatic logic [11:0] thr(input logic [1:0] s);
      return s == 2'b00 ? HMCR_THR_2K : s == 2'b01 ? HMCR_THR_1K7 :
         s == 2'b10 ? HMCR_THR_1K : HMCR_THR_512;
   endfunction

   initial
   begin
      repeat (20000) @(posedge clk);
      error_cnt++;
      stop_test();
   end

   // ***************************************************************
   // main sequence
   // ***************************************************************
   initial
   begin
      repeat (8) @(posedge clk);
      #1 resetn = 1;
      m = HMCR_MISC_RST;
      l = HMCR_LINK_RST;
      rd(HMCR_MISC_OFS);
      chk(rdat, m);
      rd(HMCR_LINK_OFS);
      chk(rdat, l);
      // corners first: all ones, all zeros, every threshold code
      for (int i = 0; i < 40; i++)
      begin
         k = i < 2 ? 0 : i < 6 ? 1 : {$random(seed)} % 3;
         wd = i < 6 ? cw[i] : $random(seed);
         be = i < 6 ? 4'hf : 4'($random(seed));
         wr(at[k], be, wd);
         if (k == 0) m = upd(m, wd, be, HMCR_MISC_WMASK);
         if (k == 1) l = upd(l, wd, be, HMCR_LINK_WMASK);
         rd(at[k]);
         chk(rdat, k == 0 ? m : k == 1 ? l : 32'h0);
         phy_enhancement_gate = i < 6 ? 1'b1 : 1'($random(seed));
         {general_pin_a_in, general_pin_b_in, general_pin_a_out, general_pin_b_out,
            general_pin_a_oe, general_pin_b_oe, clkrun_n_in, bus_busy, link_busy}
            = 9'($random(seed));
         #1;
         chk(pm_caps, {m[15], m[13], m[10]});
         chk({general_pin_a_en, general_pin_b_en, serial_clk_in, serial_data_in},
            {general_pin_a_oe & ~m[3], general_pin_b_oe & ~m[3],
            m[3] & general_pin_a_in, m[3] & general_pin_b_in});
         chk({general_pin_a_o, general_pin_b_o}, {general_pin_a_out, general_pin_b_out});
         chk(link_ctl[14:12], phy_enhancement_gate ? {l[7], l[2], l[1]} : 3'b0);
         #3;
         if (m[1]) chk(bus_clk_int, clk);
         if (m[2]) chk(link_clk_int, link_clk_in);
         @(posedge clk);
         #1 chk(link_ctl.tx_thresh, phy_enhancement_gate ? thr(l[13:12]) : HMCR_THR_1K7);
         // clock checks while the clock is high, where a gate would show
         if (m[1]) chk(bus_clk_int, clk);
         if (m[0] && clkrun_n_in) chk({clkrun_n_en, clkrun_n_o}, 2'b10);
         @(posedge link_clk_in);
         #1;
         if (m[2]) chk(link_clk_int, link_clk_in);
      end
      phy_enhancement_gate = 1;
      wr(HMCR_LINK_OFS, 4'hf, 32'h3000);
      tx_underrun = 1;
      @(posedge clk);
      #1 tx_underrun = 0;
      chk(link_ctl.tx_thresh, HMCR_THR_2K);
      tx_packet_done = 1;
      @(posedge clk);
      #1 tx_packet_done = 0;
      @(posedge clk);
      #1 chk(link_ctl.tx_thresh, HMCR_THR_512);
      for (int j = 0; j < 2; j++)
      begin
         wr(HMCR_MISC_OFS, 4'hf, {27'h0, j[0], 4'h0});
         abort_condition = 1;
         rd(8'hf8);
         abort_condition = 0;
         chk(ab, {~j[0], j[0]});
         if (j == 1) chk(rdat, 32'hffffffff);
         rom_load = '{1'b1, ($random(seed) & ~32'h40) | {25'h0, j[0], 6'h0}};
         @(posedge clk);
         #1 rom_load.load = 0;
         chk(phy_program_permit, rom_load.data[6]);
         chk(phy_program_load, 1'b1);
         rd(HMCR_LINK_OFS);
         chk(rdat, rom_load.data & HMCR_LINK_WMASK);
         chk(clkrun_n_en, 1'b0);
      end
      stop_test();
   end
endmodule

// ---- src/hmcr_clock_gate.sv ----
/*
 holds a glitch-free clock gate with a force-on override.
 assumes enable changes synchronous to clk_in.
*/
`timescale 1ns/1ps
module hmcr_clock_gate
   import hmcr_pkg::*;
(
   input wire logic clk_in,
   input wire logic gate_off,
   input wire logic run_en,
   output logic clk_out
);

   logic latch_en;

   // transparent while clock low so enable cannot chop a high phase
   always_latch
   begin
      if (!clk_in)
         latch_en = run_en | gate_off;
   end

   assign clk_out = clk_in & latch_en;

endmodule

// ---- src/hmcr_pkg.sv ----
/*
 holds offsets, field positions, reset values and carrier types of the
 miscellaneous bus configuration and link enhancement control registers.
 assumes a 32-bit configuration-space access path on the bus clock.
*/
package hmcr_pkg;

   // ***************************************************************
   // register offsets (byte addresses in configuration space)
   // ***************************************************************
   localparam logic [7:0] HMCR_MISC_OFS = 8'hf0;
   localparam logic [7:0] HMCR_LINK_OFS = 8'hf4;

   // ***************************************************************
   // reset values and writable masks
   // ***************************************************************
   localparam logic [31:0] HMCR_MISC_RST = 32'h0000_2400;
   localparam logic [31:0] HMCR_MISC_WMASK = 32'h0000_a41f;
   localparam logic [31:0] HMCR_LINK_RST = 32'h0000_1000;
   localparam logic [31:0] HMCR_LINK_WMASK = 32'h0000_3086;

   // ***************************************************************
   // field positions, miscellaneous register
   // ***************************************************************
   localparam int HMCR_M_COLD = 15;
   localparam int HMCR_M_WAKE_LOW = 13;
   localparam int HMCR_M_LOW_SUP = 10;
   localparam int HMCR_M_NO_TABT = 4;
   localparam int HMCR_M_ROUTE = 3;
   localparam int HMCR_M_LCLK_OFF = 2;
   localparam int HMCR_M_BCLK_OFF = 1;
   localparam int HMCR_M_KEEP_BCLK = 0;

   // ***************************************************************
   // field positions, link enhancement register
   // ***************************************************************
   localparam int HMCR_L_THR_HI = 13;
   localparam int HMCR_L_THR_LO = 12;
   localparam int HMCR_L_UNFAIR = 7;
   localparam int HMCR_L_ROM_PROG = 6;
   localparam int HMCR_L_IDLE = 2;
   localparam int HMCR_L_ACCEL = 1;

   // ***************************************************************
   // transmit thresholds in bytes
   // ***************************************************************
   localparam logic [11:0] HMCR_THR_2K = 12'h800;
   localparam logic [11:0] HMCR_THR_1K7 = 12'h6c0;
   localparam logic [11:0] HMCR_THR_1K = 12'h400;
   localparam logic [11:0] HMCR_THR_512 = 12'h200;

   // ***************************************************************
   // carrier types
   // ***************************************************************
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [3:0] be;
      logic [31:0] wdata;
   } hmcr_cfg_req_t;

   typedef struct packed {
      logic load;
      logic [31:0] data;
   } hmcr_rom_load_t;

   typedef struct packed {
      logic wake_from_cold_cap;
      logic wake_from_low_state_cap;
      logic low_state_supported_cap;
   } hmcr_pm_caps_t;

   typedef struct packed {
      logic unfair_en;
      logic idle_en;
      logic accel_en;
      logic [11:0] tx_thresh;
   } hmcr_link_ctl_t;

   typedef enum logic [1:0] {
      HMCR_TX_PROG = 2'b01,
      HMCR_TX_RETRY = 2'b10
   } hmcr_tx_state_t;

endpackage

// ---- src/hmcr_regs.sv ----
/*
 holds the miscellaneous bus configuration and link enhancement control
 registers with their effects on capabilities, abort policy, pin routing,
 clock gating, clock-run policy and link enhancement controls.
 assumes configuration requests are single-cycle strobes on clk.
*/
//
// Contract
// - misc reserved bits read as zero
// - misc bits 15,13,10 feed capability fields
// - no-target-abort bit swaps abort for data
// - routing bit sends pins to serial bus
// - link clock gate off runs ungated
// - bus clock gate off runs ungated
// - keep bit holds bus clock via clock-run
// - enhancements act only with phy gate set, except the 2K underrun retry, which also acts with the gate low
// - enhancements loaded by software or ROM
// - threshold field selects four byte thresholds
// - underrun retry uses 2K store-and-forward
// - bit 7 enables unfair priority requests
// - bits 2,1 enable idle insert, acceleration
// - link register reserved bits read zero
// - ROM bit 6 feeds phy program permit
`timescale 1ns/1ps
module hmcr_regs
   import hmcr_pkg::*;
(
   input wire logic clk,
   input wire logic resetn,
   input wire logic link_clk_in,
   input hmcr_cfg_req_t cfg_req,
   output logic [31:0] cfg_rdata,
   output logic cfg_rvalid,
   input wire logic abort_condition,
   output logic target_abort,
   output logic abort_data_junk,
   input hmcr_rom_load_t rom_load,
   output logic phy_program_load,
   output logic phy_program_permit,
   input wire logic phy_enhancement_gate,
   input wire logic tx_underrun,
   input wire logic tx_packet_done,
   output hmcr_link_ctl_t link_ctl,
   output hmcr_pm_caps_t pm_caps,
   input wire logic general_pin_a_in,
   input wire logic general_pin_b_in,
   input wire logic general_pin_a_out,
   input wire logic general_pin_b_out,
   input wire logic general_pin_a_oe,
   input wire logic general_pin_b_oe,
   output logic general_pin_a_o,
   output logic general_pin_b_o,
   output logic general_pin_a_en,
   output logic general_pin_b_en,
   output logic serial_clk_in,
   output logic serial_data_in,
   input wire logic clkrun_n_in,
   output logic clkrun_n_o,
   output logic clkrun_n_en,
   input wire logic bus_busy,
   input wire logic link_busy,
   output logic bus_clk_int,
   output logic link_clk_int
);

   // ***************************************************************
   // state
   // ***************************************************************
   typedef struct packed {
      logic [31:0] misc;
      logic [31:0] link;
      logic [31:0] rdata;
      logic rvalid;
      logic abort;
      logic junk;
      logic prog_permit;
      logic prog_load;
      logic [1:0] clkrun_hold;
   } hmcr_regs_state_t;

   hmcr_regs_state_t s_q, s_d;
   logic [31:0] bmask;
   logic misc_hit, link_hit;
   logic apply;

   assign apply = phy_enhancement_gate;

   always_comb
   begin
      bmask = {{8{cfg_req.be[3]}}, {8{cfg_req.be[2]}}, {8{cfg_req.be[1]}},
               {8{cfg_req.be[0]}}};
      misc_hit = (cfg_req.addr == HMCR_MISC_OFS);
      link_hit = (cfg_req.addr == HMCR_LINK_OFS);
      s_d = s_q;
      s_d.rvalid = cfg_req.rd;
      s_d.prog_load = 1'b0;

      // ***************************************************************
      // register writes
      // ***************************************************************
      if (cfg_req.wr && misc_hit)
         s_d.misc = (s_q.misc & ~(HMCR_MISC_WMASK & bmask)) |
                    (cfg_req.wdata & HMCR_MISC_WMASK & bmask);
      if (cfg_req.wr && link_hit)
         s_d.link = (s_q.link & ~(HMCR_LINK_WMASK & bmask)) |
                    (cfg_req.wdata & HMCR_LINK_WMASK & bmask);
      if (rom_load.load)
      begin
         s_d.link = rom_load.data & HMCR_LINK_WMASK;
         s_d.prog_permit = rom_load.data[HMCR_L_ROM_PROG];
         s_d.prog_load = 1'b1;
      end

      // ***************************************************************
      // reads, with abort or junk data on a faulting access
      // ***************************************************************
      if (misc_hit)
         s_d.rdata = s_q.misc & HMCR_MISC_WMASK;
      else if (link_hit)
         s_d.rdata = s_q.link & HMCR_LINK_WMASK;
      else
         s_d.rdata = 32'h0000_0000;
      s_d.abort = 1'b0;
      s_d.junk = 1'b0;
      if ((cfg_req.rd || cfg_req.wr) && abort_condition)
      begin
         if (s_q.misc[HMCR_M_NO_TABT])
         begin
            s_d.junk = 1'b1;
            s_d.rdata = 32'hffff_ffff;
         end
         else
            s_d.abort = 1'b1;
      end

      // ***************************************************************
      // clock-run: claim the clock back when a stop is requested
      // ***************************************************************
      if (s_q.misc[HMCR_M_KEEP_BCLK] && clkrun_n_in)
         s_d.clkrun_hold = 2'b11;
      else if (s_q.clkrun_hold != 2'b00)
         s_d.clkrun_hold = s_q.clkrun_hold - 2'b01;
   end

   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         s_q.misc <= HMCR_MISC_RST;
         s_q.link <= HMCR_LINK_RST;
         s_q.rdata <= 32'h0000_0000;
         s_q.rvalid <= 1'b0;
         s_q.abort <= 1'b0;
         s_q.junk <= 1'b0;
         s_q.prog_permit <= 1'b0;
         s_q.prog_load <= 1'b0;
         s_q.clkrun_hold <= 2'b00;
      end
      else
         s_q <= s_d;
   end

   // ***************************************************************
   // outputs
   // ***************************************************************
   assign cfg_rdata = s_q.rdata;
   assign cfg_rvalid = s_q.rvalid;
   assign target_abort = s_q.abort;
   assign abort_data_junk = s_q.junk;
   assign phy_program_permit = s_q.prog_permit;
   assign phy_program_load = s_q.prog_load;

   assign pm_caps.wake_from_cold_cap = s_q.misc[HMCR_M_COLD];
   assign pm_caps.wake_from_low_state_cap = s_q.misc[HMCR_M_WAKE_LOW];
   assign pm_caps.low_state_supported_cap = s_q.misc[HMCR_M_LOW_SUP];

   assign link_ctl.unfair_en = apply & s_q.link[HMCR_L_UNFAIR];
   assign link_ctl.idle_en = apply & s_q.link[HMCR_L_IDLE];
   assign link_ctl.accel_en = apply & s_q.link[HMCR_L_ACCEL];

   hmcr_tx_threshold u_thr
   (
      .clk(clk),
      .resetn(resetn),
      .thresh_sel(s_q.link[HMCR_L_THR_HI:HMCR_L_THR_LO]),
      .apply_en(apply),
      .tx_underrun(tx_underrun),
      .tx_packet_done(tx_packet_done),
      .tx_thresh(link_ctl.tx_thresh)
   );

   // pins hand over to the serial bus and float when routed
   assign general_pin_a_o = general_pin_a_out;
   assign general_pin_b_o = general_pin_b_out;
   assign general_pin_a_en = general_pin_a_oe & ~s_q.misc[HMCR_M_ROUTE];
   assign general_pin_b_en = general_pin_b_oe & ~s_q.misc[HMCR_M_ROUTE];
   assign serial_data_in = s_q.misc[HMCR_M_ROUTE] & general_pin_b_in;
   assign serial_clk_in = s_q.misc[HMCR_M_ROUTE] & general_pin_a_in;

   assign clkrun_n_o = 1'b0;
   assign clkrun_n_en = s_q.clkrun_hold != 2'b00;

   hmcr_clock_gate u_bus_gate
   (
      .clk_in(clk),
      .gate_off(s_q.misc[HMCR_M_BCLK_OFF]),
      .run_en(bus_busy | cfg_req.rd | cfg_req.wr),
      .clk_out(bus_clk_int)
   );

   hmcr_clock_gate u_link_gate
   (
      .clk_in(link_clk_in),
      .gate_off(s_q.misc[HMCR_M_LCLK_OFF]),
      .run_en(link_busy),
      .clk_out(link_clk_int)
   );

endmodule

// ---- src/hmcr_tx_threshold.sv ----
/*
 holds the transmit threshold selector with underrun fallback to
 store-and-forward for the retried packet.
 assumes one-cycle pulses for underrun and packet completion.
*/
`timescale 1ns/1ps
module hmcr_tx_threshold
   import hmcr_pkg::*;
(
   input wire logic clk,
   input wire logic resetn,
   input wire logic [1:0] thresh_sel,
   input wire logic apply_en,
   input wire logic tx_underrun,
   input wire logic tx_packet_done,
   output logic [11:0] tx_thresh
);

   typedef struct packed {
      hmcr_tx_state_t st;
      logic [11:0] thr;
   } hmcr_thr_state_t;

   hmcr_thr_state_t s_q, s_d;
   logic [11:0] prog_thr;

   always_comb
   begin
      case (thresh_sel)
         2'b00: prog_thr = HMCR_THR_2K;
         2'b01: prog_thr = HMCR_THR_1K7;
         2'b10: prog_thr = HMCR_THR_1K;
         default: prog_thr = HMCR_THR_512;
      endcase
      if (!apply_en)
         prog_thr = HMCR_THR_1K7;
      s_d = s_q;
      case (s_q.st)
         HMCR_TX_PROG:
         begin
            if (tx_underrun)
               s_d.st = HMCR_TX_RETRY;
         end
         HMCR_TX_RETRY:
         begin
            if (tx_packet_done && !tx_underrun)
               s_d.st = HMCR_TX_PROG;
         end
         default: s_d.st = HMCR_TX_PROG;
      endcase
      s_d.thr = (s_d.st == HMCR_TX_RETRY) ? HMCR_THR_2K : prog_thr;
   end

   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         s_q.st <= HMCR_TX_PROG;
         s_q.thr <= HMCR_THR_1K7;
      end
      else
         s_q <= s_d;
   end

   assign tx_thresh = s_q.thr;

endmodule
